// File: verilog/mii_port_pkg.sv
// Constants shared by the MII/symbol port and its management engine.
// Assumes a single 100 MHz system clock; PHY clocks arrive as plain pins.
// Operation
// - A decode error during a frame flags CRC error in the descriptor status.
// - Decode error is rx-clock synchronous; a one-cycle pulse must be caught.
// - Device generates the management clock that times every management transfer.
// - Management data line is two-way; device and PHY drive it in turn.
// - Port select output high for MII/symbol port, low for serial port.
// - Transmit lines change with the transmit clock; PHY samples on its rise.
// - Transmit enable marks transmission; meaningless in symbol coding mode.
// - Address match output asserts when a frame passes address filtering.
// - Symbol coding mode adds a fifth data line in each direction.
package mii_port_pkg;
  localparam int CLK_MHZ          = 100;
  // Management clock half period, least time
  localparam int MDC_HALF_NS      = 200;
  localparam int MDC_HALF_CYC     = (MDC_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int MGMT_FRAME_BITS  = 64;
  localparam int MGMT_PREAMBLE    = 32;
  localparam int MGMT_TA_POS      = 46;
  localparam int MGMT_DATA_POS    = 48;
  localparam logic [1:0]  MGMT_START    = 2'h1;
  localparam logic [1:0]  MGMT_OP_READ  = 2'h2;
  localparam logic [1:0]  MGMT_OP_WRITE = 2'h1;
  localparam logic [1:0]  MGMT_TA_WRITE = 2'h2;
  localparam logic [31:0] MGMT_PREAMBLE_BITS = 32'hffffffff;
  localparam int SYM_W            = 5;
  localparam int NIB_W            = 4;
  localparam logic [15:0] MGMT_RDATA_RST = 16'h0000;
  typedef enum logic [0:0] {MGMT_IDLE, MGMT_SHIFT} mgmt_state_t;
endpackage

// File: verilog/mgmt_if.sv
// Request and answer bundle between the port top and the management engine.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface mgmt_if;
  logic        start;
  logic        write;
  logic [4:0]  phy_addr;
  logic [4:0]  reg_addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        busy;
  logic        done;
  logic        mdio_in_s;
  modport ctrl   (output start, write, phy_addr, reg_addr, wdata, mdio_in_s,
                  input rdata, busy, done);
  modport engine (input start, write, phy_addr, reg_addr, wdata, mdio_in_s,
                  output rdata, busy, done);
endinterface

// File: verilog/mgmt_engine.sv
// Management frame engine: makes the management clock and shifts frames.
// Assumes its data input is already synchronised to clk.
`timescale 1ns/1ps
module mgmt_engine
  import mii_port_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  mgmt_if.engine    mg,
  output logic      mdc,
  output logic      mdio_out,
  output logic      mdio_oe
);
  import mii_port_pkg::*;

  mgmt_state_t state_reg;
  logic [7:0]  half_cnt_reg;
  logic [6:0]  idx_reg;
  logic [63:0] frame_reg;
  logic        read_reg;
  logic [15:0] rdata_reg;
  logic        done_reg;
  wire         half_tick = (half_cnt_reg == 8'(MDC_HALF_CYC - 1));

  // ----------------------------------------
  // Clock divider and bit sequencing
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= MGMT_IDLE;
      half_cnt_reg <= 8'h00;
      idx_reg      <= 7'h00;
      frame_reg    <= 64'h0;
      read_reg     <= 1'b0;
      mdc          <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        MGMT_IDLE: begin
          half_cnt_reg <= 8'h00;
          mdc          <= 1'b0;
          if (mg.start) begin
            state_reg <= MGMT_SHIFT;
            idx_reg   <= 7'h00;
            read_reg  <= !mg.write;
            frame_reg <= {MGMT_PREAMBLE_BITS, MGMT_START,
                          mg.write ? MGMT_OP_WRITE : MGMT_OP_READ,
                          mg.phy_addr, mg.reg_addr, MGMT_TA_WRITE, mg.wdata};
          end
        end
        MGMT_SHIFT: begin
          half_cnt_reg <= half_tick ? 8'h00 : half_cnt_reg + 8'h01;
          if (half_tick) begin
            mdc <= !mdc;
            if (mdc) begin
              frame_reg <= {frame_reg[62:0], 1'b0};
              if (idx_reg == 7'(MGMT_FRAME_BITS - 1)) begin
                state_reg <= MGMT_IDLE;
                done_reg  <= 1'b1;
              end else begin
                idx_reg <= idx_reg + 7'h01;
              end
            end
          end
        end
        default: state_reg <= MGMT_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Line drive and read capture
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else begin
      mdio_out <= (state_reg == MGMT_SHIFT) ? frame_reg[63] : 1'b0;
      mdio_oe  <= (state_reg == MGMT_SHIFT)
                  && !(read_reg && idx_reg >= 7'(MGMT_TA_POS));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= MGMT_RDATA_RST;
    end else if (state_reg == MGMT_SHIFT && half_tick && !mdc && read_reg
                 && idx_reg >= 7'(MGMT_DATA_POS)) begin
      rdata_reg <= {rdata_reg[14:0], mg.mdio_in_s};
    end
  end

  assign mg.rdata = rdata_reg;
  assign mg.busy  = (state_reg == MGMT_SHIFT);
  assign mg.done  = done_reg;

  chk_mdc_half_period : assert property (@(posedge clk) disable iff (!reset_n)
    $rose(mdc) |-> ##20 $fell(mdc))
    else $error("management clock high time wrong");
  chk_mdio_turnaround : assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == MGMT_SHIFT && read_reg && idx_reg >= 7'(MGMT_TA_POS)) |=> !mdio_oe)
    else $error("data line driven during read data");
  chk_mgmt_preamble : assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == MGMT_SHIFT && $past(state_reg) == MGMT_SHIFT
     && idx_reg < 7'(MGMT_PREAMBLE)) |=> (mdio_out && mdio_oe))
    else $error("preamble bit not one");
endmodule

// File: verilog/mii_symbol_port.sv
// MII/symbol media port: receive, transmit, selects and management port.
// Assumes PHY clocks and data are asynchronous pins sampled by clk.
`timescale 1ns/1ps
module mii_symbol_port
  import mii_port_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      symbol_coding_mode,
  input  wire logic                      port_select_mii,
  input  wire logic                      addr_filter_pass,
  input  wire logic                      rx_clk_pin,
  input  wire logic [mii_port_pkg::NIB_W-1:0] rxd_pin,
  input  wire logic                      rxd4_pin,
  input  wire logic                      rx_valid_in,
  input  wire logic                      rx_err_pin,
  input  wire logic                      crs_pin,
  input  wire logic                      col_pin,
  input  wire logic                      tx_clk_pin,
  input  wire logic                      tx_valid,
  input  wire logic [mii_port_pkg::SYM_W-1:0] tx_data,
  input  wire logic                      mgmt_start,
  input  wire logic                      mgmt_write,
  input  wire logic [4:0]                mgmt_phy_addr,
  input  wire logic [4:0]                mgmt_reg_addr,
  input  wire logic [15:0]               mgmt_wdata,
  input  wire logic                      mdio_in,
  output logic [mii_port_pkg::SYM_W-1:0] rx_sym_reg,
  output logic                           rx_sym_valid_reg,
  output logic                           rx_end_reg,
  output logic                           rx_crc_error_reg,
  output logic                           carrier_sense_reg,
  output logic                           collision_reg,
  output logic [mii_port_pkg::NIB_W-1:0] txd_reg,
  output logic                           txd4_reg,
  output logic                           tx_en_reg,
  output logic                           tx_taken_reg,
  output logic                           mii_select_reg,
  output logic                           addr_match_reg,
  output logic [15:0]                    mgmt_rdata,
  output logic                           mgmt_busy,
  output logic                           mgmt_done,
  output logic                           mdc,
  output logic                           mdio_out,
  output logic                           mdio_oe
);
  import mii_port_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int SW = 12;
  logic [SW-1:0] pin_m_reg;
  logic [SW-1:0] pin_s_reg;
  logic          rclk_d_reg;
  logic          tclk_d_reg;
  logic          dv_d_reg;
  logic          err_pend_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_m_reg <= '0;
      pin_s_reg <= '0;
    end else begin
      pin_m_reg <= {rx_clk_pin, tx_clk_pin, rx_valid_in, rx_err_pin, crs_pin, col_pin,
                    mdio_in, rxd4_pin, rxd_pin};
      pin_s_reg <= pin_m_reg;
    end
  end

  wire       rclk_s = pin_s_reg[11];
  wire       tclk_s = pin_s_reg[10];
  wire       dv_s   = pin_s_reg[9];
  wire       err_s  = pin_s_reg[8];
  wire [4:0] sym_s  = pin_s_reg[4:0];
  wire       rx_rise = rclk_s && !rclk_d_reg;
  wire       tx_rise = tclk_s && !tclk_d_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rclk_d_reg <= 1'b0;
      tclk_d_reg <= 1'b0;
    end else begin
      rclk_d_reg <= rclk_s;
      tclk_d_reg <= tclk_s;
    end
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sym_reg       <= 5'h00;
      rx_sym_valid_reg <= 1'b0;
      dv_d_reg         <= 1'b0;
    end else begin
      rx_sym_valid_reg <= 1'b0;
      if (rx_rise) begin
        dv_d_reg <= dv_s;
        if (dv_s || symbol_coding_mode) begin
          rx_sym_reg       <= {symbol_coding_mode && sym_s[4], sym_s[3:0]};
          rx_sym_valid_reg <= 1'b1;
        end
      end
    end
  end

  // Error caught on any single sampled edge with data valid high, reported at frame end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_pend_reg     <= 1'b0;
      rx_end_reg       <= 1'b0;
      rx_crc_error_reg <= 1'b0;
    end else begin
      rx_end_reg <= 1'b0;
      if (rx_rise) begin
        if (dv_d_reg && !dv_s) begin
          rx_end_reg       <= 1'b1;
          rx_crc_error_reg <= err_pend_reg;
          err_pend_reg     <= 1'b0;
        end else if (dv_s && err_s) begin
          err_pend_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carrier_sense_reg <= 1'b0;
      collision_reg     <= 1'b0;
    end else begin
      carrier_sense_reg <= pin_s_reg[7];
      collision_reg     <= pin_s_reg[6];
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txd_reg      <= 4'h0;
      txd4_reg     <= 1'b0;
      tx_en_reg    <= 1'b0;
      tx_taken_reg <= 1'b0;
    end else begin
      tx_taken_reg <= 1'b0;
      if (tx_rise) begin
        if (tx_valid) begin
          txd_reg      <= tx_data[3:0];
          txd4_reg     <= symbol_coding_mode && tx_data[4];
          tx_en_reg    <= !symbol_coding_mode;
          tx_taken_reg <= 1'b1;
        end else begin
          txd_reg   <= 4'h0;
          txd4_reg  <= 1'b0;
          tx_en_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Port select and address match
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mii_select_reg <= 1'b0;
      addr_match_reg <= 1'b0;
    end else begin
      mii_select_reg <= port_select_mii;
      addr_match_reg <= addr_filter_pass;
    end
  end

  // ----------------------------------------
  // Management port
  // ----------------------------------------
  mgmt_if mg ();
  assign mg.start     = mgmt_start;
  assign mg.write     = mgmt_write;
  assign mg.phy_addr  = mgmt_phy_addr;
  assign mg.reg_addr  = mgmt_reg_addr;
  assign mg.wdata     = mgmt_wdata;
  assign mg.mdio_in_s = pin_s_reg[5];
  assign mgmt_rdata   = mg.rdata;
  assign mgmt_busy    = mg.busy;
  assign mgmt_done    = mg.done;

  mgmt_engine u_mgmt (
    .clk      (clk),
    .reset_n  (reset_n),
    .mg       (mg),
    .mdc      (mdc),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe)
  );

  chk_err_single_edge : assert property (@(posedge clk) disable iff (!reset_n)
    (rx_rise && dv_s && dv_d_reg && err_s) |=> err_pend_reg)
    else $error("one-edge decode error missed");
  chk_crc_on_end : assert property (@(posedge clk) disable iff (!reset_n)
    (rx_rise && dv_d_reg && !dv_s && err_pend_reg) |=> (rx_end_reg && rx_crc_error_reg))
    else $error("crc error not reported at frame end");
  chk_rx_nibble : assert property (@(posedge clk) disable iff (!reset_n)
    (rx_rise && dv_s) |=> (rx_sym_valid_reg && rx_sym_reg[3:0] == $past(sym_s[3:0])))
    else $error("received nibble not delivered");
  chk_txd_load : assert property (@(posedge clk) disable iff (!reset_n)
    (tx_rise && tx_valid) |=> (tx_taken_reg && txd_reg == $past(tx_data[3:0])))
    else $error("transmit nibble not loaded");
  chk_txen_active : assert property (@(posedge clk) disable iff (!reset_n)
    (tx_rise && tx_valid && !symbol_coding_mode) |=> tx_en_reg ##1 !tx_taken_reg)
    else $error("transmit enable missing");
  chk_txen_idle : assert property (@(posedge clk) disable iff (!reset_n)
    (tx_rise && !tx_valid) |=> (!tx_en_reg && !tx_taken_reg))
    else $error("transmit enable without data");
  chk_port_select : assert property (@(posedge clk) disable iff (!reset_n)
    ##1 (mii_select_reg == $past(port_select_mii)))
    else $error("port select wrong");
  chk_addr_match : assert property (@(posedge clk) disable iff (!reset_n)
    addr_filter_pass |=> addr_match_reg)
    else $error("address match not shown");
endmodule

// File: test/phy_model.sv
// PHY stand-in: framed receive clock, free transmit clock, management answers.
// Assumes the port samples every pin with its own system clock.
`timescale 1ns/1ps
module phy_model #(
  parameter logic [15:0] RD_VAL = 16'h5a3c
) (
  output logic            rx_clk,
  output logic [3:0]      rxd,
  output logic            rxd4,
  output logic            rx_dv,
  output logic            rx_err,
  output logic            crs,
  output logic            col,
  output logic            tx_clk,
  input  wire logic [3:0] txd,
  input  wire logic       txd4,
  output logic [4:0]      tx_seen,
  output int              tx_rises,
  input  wire logic       mdc,
  input  wire logic       dut_oe,
  output logic            md_out,
  output logic            md_oe
);
  // ----------------------------------------------------------------
  // Receive frames, transmit capture, management replies
  // ----------------------------------------------------------------
  int         nbit;
  logic [4:0] s;
  initial begin
    {rx_clk, rxd, rxd4, rx_dv, rx_err, crs, col, tx_clk, md_out, md_oe} = '0;
    tx_rises = 0;
    nbit = 64;
    forever #62.5 tx_clk = ~tx_clk;
  end
  always @(posedge tx_clk) begin
    tx_seen <= {txd4, txd};
    tx_rises <= tx_rises + 1;
  end
  // Clock runs only inside a frame, plus two trailing edges
  task automatic rx_frame(input int n, input int err_at, input logic sym);
    for (int k = 0; k < n + 2; k++) begin
      s = 5'(k * 7 + 3);
      rx_dv = (k < n);
      crs = (k < n);
      rx_err = (k == err_at);
      rxd = (k < n) ? s[3:0] : 4'h0;
      rxd4 = sym ? (s[4] & (k < n)) : 1'b1;
      #62.5 rx_clk = 1'b1;
      #62.5 rx_clk = 1'b0;
    end
    rx_err = 1'b0;
    rxd = ~rxd;
  endtask
  task automatic collide(input logic v);
    col = v;
  endtask
  always @(posedge dut_oe) nbit = 0;
  always @(posedge mdc) nbit = nbit + 1;
  always @(negedge mdc) begin
    md_oe <= !dut_oe && nbit >= 47 && nbit <= 63;
    md_out <= (nbit == 47) ? 1'b0 : RD_VAL[4'(63 - nbit)];
  end
endmodule

// File: test/mii_symbol_port_tb.sv
// Self-checking bench for the MII/symbol port against the PHY stand-in.
// Assumes the package, the port design and phy_model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module mii_symbol_port_tb;
  import mii_port_pkg::*;
  // ----------------------------------------------------------------
  // Signals, design, partner and monitor
  // ----------------------------------------------------------------
  localparam logic [15:0] RD_VAL = 16'h5a3c;
  logic        clk, reset_n, symbol_coding_mode, port_select_mii, addr_filter_pass;
  logic        rx_clk_pin, rxd4_pin, rx_valid_in, rx_err_pin, crs_pin, col_pin, tx_clk_pin;
  logic [3:0]  rxd_pin, txd_reg;
  logic [4:0]  tx_data, rx_sym_reg, phy_seen, mgmt_phy_addr, mgmt_reg_addr;
  logic        tx_valid, mgmt_start, mgmt_write, mdio_in, rx_sym_valid_reg, rx_end_reg;
  logic        rx_crc_error_reg, carrier_sense_reg, collision_reg, txd4_reg, tx_en_reg;
  logic        tx_taken_reg, mii_select_reg, addr_match_reg, mgmt_busy, mgmt_done;
  logic        mdc, mdio_out, mdio_oe, md_out, md_oe, mdc_q;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [63:0] cap;
  logic [4:0]  rxq[$];
  int          fail_count = 0, n_checks = 0, ends = 0, rises = 0, dones = 0;
  int          cyc = 0, period = 0, c0, tx_rises, crs_cyc = 0;
  // Pull-up when nobody drives the line
  assign mdio_in = mdio_oe ? mdio_out : (md_oe ? md_out : 1'b1);
  mii_symbol_port dut (.clk, .reset_n, .symbol_coding_mode, .port_select_mii, .addr_filter_pass,
    .rx_clk_pin, .rxd_pin, .rxd4_pin, .rx_valid_in, .rx_err_pin, .crs_pin, .col_pin, .tx_clk_pin,
    .tx_valid, .tx_data, .mgmt_start, .mgmt_write, .mgmt_phy_addr, .mgmt_reg_addr, .mgmt_wdata,
    .mdio_in, .rx_sym_reg, .rx_sym_valid_reg, .rx_end_reg, .rx_crc_error_reg, .carrier_sense_reg,
    .collision_reg, .txd_reg, .txd4_reg, .tx_en_reg, .tx_taken_reg, .mii_select_reg,
    .addr_match_reg, .mgmt_rdata, .mgmt_busy, .mgmt_done, .mdc, .mdio_out, .mdio_oe);
  phy_model #(.RD_VAL(RD_VAL)) phy (.rx_clk(rx_clk_pin), .rxd(rxd_pin), .rxd4(rxd4_pin),
    .rx_dv(rx_valid_in), .rx_err(rx_err_pin), .crs(crs_pin), .col(col_pin), .tx_clk(tx_clk_pin),
    .txd(txd_reg), .txd4(txd4_reg), .tx_seen(phy_seen), .tx_rises, .mdc, .dut_oe(mdio_oe),
    .md_out, .md_oe);
  always @(posedge clk) begin
    mdc_q <= mdc;
    cyc <= (mdc && !mdc_q) ? 0 : cyc + 1;
    if (mdc && !mdc_q) begin
      cap <= {cap[62:0], mdio_in};
      rises <= rises + 1;
      period <= cyc + 1;
    end
    if (rx_sym_valid_reg === 1'b1) rxq.push_back(rx_sym_reg);
    if (rx_end_reg === 1'b1) ends <= ends + 1;
    if (carrier_sense_reg === 1'b1) crs_cyc <= crs_cyc + 1;
    if (mgmt_done === 1'b1) dones <= dones + 1;
  end
  // ----------------------------------------------------------------
  // Waits, verdict and scenarios
  // ----------------------------------------------------------------
  function automatic logic flag(input int w);
    case (w)
      0: return tx_taken_reg;
      1: return mgmt_done;
      2: return collision_reg;
      3: return !collision_reg;
      4: return tx_rises != c0;
      5: return ends != c0;
      default: return rises - c0 >= 10;
    endcase
  endfunction
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_flag(input int w, input int lim);
    for (int k = 0; k < lim && flag(w) !== 1'b1; k++) @(posedge clk);
    if (flag(w) !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED wait %0d expected 1 seen 0", w);
      stop_test();
    end
  endtask
  task automatic sc_levels();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      port_select_mii <= v[0];
      addr_filter_pass <= !v[0];
      repeat (2) @(posedge clk);
      `CHK("mii_select", v[0], mii_select_reg)
      `CHK("addr_match", !v[0], addr_match_reg)
    end
    phy.collide(1'b1);
    wait_flag(2, 10);
    phy.collide(1'b0);
    wait_flag(3, 10);
    `CHK("collision", 1'b0, collision_reg)
  endtask
  task automatic sc_rx(input int n, input int err_at, input logic sym, input logic exp_err);
    logic [4:0] s;
    int         cnt;
    int         c1;
    @(posedge clk);
    symbol_coding_mode <= sym;
    @(posedge clk);
    rxq.delete();
    c0 = ends;
    c1 = crs_cyc;
    phy.rx_frame(n, err_at, sym);
    wait_flag(5, 20);
    cnt = sym ? n + 2 : n;
    `CHK("rx_count", cnt, rxq.size())
    for (int k = 0; k < cnt && k < rxq.size(); k++) begin
      s = 5'(k * 7 + 3);
      if (k >= n) s = 5'h00;
      else if (!sym) s[4] = 1'b0;
      `CHK("rx_sym", s, rxq[k])
    end
    `CHK("crc_error", exp_err, rx_crc_error_reg)
    `CHK("carrier", 1'b0, carrier_sense_reg)
    `CHK("carrier_seen", 1'b1, crs_cyc > c1)
  endtask
  task automatic sc_tx(input logic sym);
    logic [4:0] d;
    @(posedge clk);
    symbol_coding_mode <= sym;
    for (int j = 0; j < 3; j++) begin
      d = 5'(j * 9 + 5);
      if (!sym) d[4] = 1'b0;
      tx_valid <= 1'b1;
      tx_data <= d;
      wait_flag(0, 40);
      `CHK("txd", d[3:0], txd_reg)
      `CHK("txd4", d[4], txd4_reg)
      `CHK("tx_en", !sym, tx_en_reg)
      c0 = tx_rises;
      wait_flag(4, 20);
      `CHK("phy_seen", d, phy_seen)
    end
    tx_valid <= 1'b0;
    c0 = tx_rises;
    wait_flag(4, 20);
    `CHK("tx_en_idle", 1'b0, tx_en_reg)
  endtask
  task automatic sc_mgmt(input logic wr, input logic bump);
    logic [63:0] e;
    int          d0;
    @(posedge clk);
    mgmt_write <= wr;
    mgmt_phy_addr <= 5'h13;
    mgmt_reg_addr <= 5'h0b;
    mgmt_wdata <= 16'hc3a5;
    mgmt_start <= 1'b1;
    c0 = rises;
    d0 = dones;
    @(posedge clk);
    mgmt_start <= 1'b0;
    @(posedge clk);
    `CHK("busy_on", 1'b1, mgmt_busy)
    if (bump) begin
      wait_flag(6, 800);
      mgmt_start <= 1'b1;
      @(posedge clk);
      mgmt_start <= 1'b0;
    end
    wait_flag(1, 3000);
    @(posedge clk);
    e = {MGMT_PREAMBLE_BITS, MGMT_START, wr ? MGMT_OP_WRITE : MGMT_OP_READ, 5'h13, 5'h0b,
         MGMT_TA_WRITE, wr ? 16'hc3a5 : RD_VAL};
    `CHK("frame", e, cap)
    `CHK("mdc_bits", MGMT_FRAME_BITS, rises - c0)
    `CHK("mdc_period", 2 * MDC_HALF_CYC, period)
    `CHK("done_count", d0 + 1, dones)
    `CHK("busy", 1'b0, mgmt_busy)
    if (!wr) `CHK("rdata", RD_VAL, mgmt_rdata)
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {reset_n, symbol_coding_mode, port_select_mii, addr_filter_pass} = '0;
    {tx_valid, tx_data, mgmt_start, mgmt_write, mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata} = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    sc_levels();
    sc_rx(8, 3, 1'b0, 1'b1);
    sc_rx(8, 8, 1'b0, 1'b0);
    sc_rx(1, 0, 1'b0, 1'b1);
    sc_rx(6, -1, 1'b1, 1'b0);
    sc_tx(1'b0);
    sc_tx(1'b1);
    sc_mgmt(1'b1, 1'b1);
    sc_mgmt(1'b0, 1'b0);
    stop_test();
  end
endmodule
